// File: bench/flash_array_model.sv
// array side model: byte contents derived from the address
`timescale 1ns/1ps
module flash_array_model (
    // array read port
    input wire logic [18:0] array_addr,
    output logic [7:0] array_data
);
    // pattern differs from both identification codes
    assign array_data = array_addr[7:0] ^ 8'hA5;
endmodule

// File: bench/flash_id_checker_assertions.sv
// concurrent checks on the ports of the flash id readout block
`timescale 1ns/1ps
module flash_id_checker #(
    parameter int PAGE_ERASE_CYCLES = 50,
    parameter int CHIP_ERASE_CYCLES = 100,
    parameter int PU_READ_CYCLES = 4,
    parameter int PU_WRITE_CYCLES = 8
) (
    // watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic top_block_lock_pin_n,
    input wire logic write_protect_pin_n,
    input wire logic [18:0] array_addr,
    input wire logic erase_busy
);
    int cyc_q;
    int run_q;
    int pin_q;
    logic [1:0] pins_q;
    logic rd_acc;
    assign rd_acc = psel && penable && !pwrite && clk_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= 0;
            run_q <= 0;
            pin_q <= 0;
            pins_q <= 2'b11;
        end else begin
            cyc_q <= clk_en ? cyc_q + 1 : cyc_q;
            run_q <= !erase_busy ? 0 : (clk_en ? run_q + 1 : run_q);
            pins_q <= {write_protect_pin_n, top_block_lock_pin_n};
            pin_q <= (pins_q != {write_protect_pin_n, top_block_lock_pin_n}) ? 0 :
                     (clk_en ? pin_q + 1 : pin_q);
        end
    end
    // ======================================================================
    // assertions
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_in_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
        else $error("unmapped access without pslverr");
    a_prdata_hold: assert property (!(psel && penable && !pwrite) |-> $stable(prdata))
        else $error("prdata changed outside read");
    a_addr_follow: assert property (
        psel && penable && pwrite && clk_en && paddr == 12'h008
        |=> array_addr == 19'($past(pwdata))) else $error("array address not loaded");
    a_lock_pins: assert property (rd_acc && paddr == 12'h014 && pin_q >= 3
        && pins_q == {write_protect_pin_n, top_block_lock_pin_n}
        |-> prdata[3:2] == {!write_protect_pin_n, !top_block_lock_pin_n})
        else $error("pin lock bits wrong");
    a_early_read: assert property (
        rd_acc && paddr == 12'h00C && cyc_q + 1 < PU_READ_CYCLES
        |-> prdata == 32'h0) else $error("read served too early");
    a_busy_start: assert property ($rose(erase_busy) |-> cyc_q >= PU_WRITE_CYCLES)
        else $error("erase started before write delay");
    a_busy_len: assert property ($fell(erase_busy) |-> run_q inside
        {[PAGE_ERASE_CYCLES-2:PAGE_ERASE_CYCLES+2], [CHIP_ERASE_CYCLES-2:CHIP_ERASE_CYCLES+2]})
        else $error("erase length wrong");
endmodule
bind flash_id_lock_status_readout flash_id_checker #(
    .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES), .CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES),
    .PU_READ_CYCLES(PU_READ_CYCLES), .PU_WRITE_CYCLES(PU_WRITE_CYCLES)
) chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .top_block_lock_pin_n, .write_protect_pin_n, .array_addr, .erase_busy);

// File: bench/flash_id_lock_status_readout_test.sv
// self-checking bench of the flash id readout block
`timescale 1ns/1ps
module flash_id_lock_status_readout_test;
    localparam logic [7:0] MFR = 8'h3C; // arbitrary value
    localparam logic [7:0] DEV = 8'h96; // arbitrary value
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic boot_lock_n = 1, wp_n = 1, pready, pslverr, erase_busy, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [18:0] array_addr;
    logic [7:0] array_data;
    int err_total = 0, tests_run = 0, cyc = 0;
    always #25 pclk = ~pclk;
    flash_id_lock_status_readout #(.MANUFACTURER_CODE(MFR), .DEVICE_CODE(DEV),
        .PAGE_ERASE_CYCLES(50), .CHIP_ERASE_CYCLES(100), .PU_READ_CYCLES(4),
        .PU_WRITE_CYCLES(8)) dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .top_block_lock_pin_n(boot_lock_n),
        .write_protect_pin_n(wp_n), .array_addr, .array_data, .erase_busy);
    flash_array_model mem (.array_addr, .array_data);
    always @(posedge pclk) if (++cyc > 20000) begin err_total++; end_sim(); end
    // ======================================================================
    // bus and compare tasks
    task end_sim;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task cmd(input logic [18:0] a, input logic [7:0] d);
        apb(1, 12'h000, {13'h0, a});
        apb(1, 12'h004, {24'h0, d});
    endtask
    task unlock(input logic [7:0] d);
        cmd(19'h5555, 8'hAA);
        cmd(19'h2AAA, 8'h55);
        cmd(19'h5555, d);
    endtask
    task six(input logic [7:0] d);
        unlock(8'h80);
        unlock(d);
    endtask
    task rdarr(input logic [18:0] a);
        apb(1, 12'h008, {13'h0, a});
        apb(0, 12'h00C, 32'h0);
    endtask
    task reset_dut;
        presetn <= 0;
        repeat (6) @(posedge pclk);
        presetn <= 1;
    endtask
    // ======================================================================
    // scenarios
    task t_power;
        reset_dut();
        apb(0, 12'h00C, 32'h0);
        check(rd, 32'h0);
        reset_dut();
        unlock(8'h90);
        apb(0, 12'h010, 32'h0);
        check(rd & 32'h1, 32'h0);
        $display("power-up test done");
    endtask
    task t_id;
        repeat (10) @(posedge pclk);
        cmd(19'h7D555, 8'hAA);
        cmd(19'h2AAA, 8'h55);
        cmd(19'h5555, 8'h90);
        rdarr(19'h0);
        check(rd & 32'hFF, {24'h0, MFR});
        rdarr(19'h1);
        check(rd & 32'hFF, {24'h0, DEV});
        boot_lock_n <= 0;
        repeat (4) @(posedge pclk);
        rdarr(19'h2);
        check(rd & 32'hF, 32'h4);
        {boot_lock_n, wp_n} <= 2'b10;
        repeat (4) @(posedge pclk);
        apb(0, 12'h014, 32'h0);
        check(rd & 32'hF, 32'h8);
        wp_n <= 1;
        clk_en <= 0;
        cmd(19'h0, 8'hF0);
        clk_en <= 1;
        apb(0, 12'h010, 32'h0);
        check(rd & 32'h1, 32'h1);
        cmd(19'h1234, 8'hF0);
        rdarr(19'h0);
        check(rd & 32'hFF, 32'hA5);
        unlock(8'h90);
        unlock(8'hF0);
        rdarr(19'h3);
        check(rd & 32'hFF, 32'hA6);
        $display("identification test done");
    endtask
    task t_locks_erase;
        logic [7:0] c[3];
        int l[3];
        int n;
        c = '{8'h10, 8'h30, 8'h50};
        l = '{100, 50, 50};
        six(8'h40);
        six(8'h70);
        unlock(8'h90);
        rdarr(19'h2);
        check(rd & 32'hF, 32'h3);
        cmd(19'h0, 8'hF0);
        for (int i = 0; i < 3; i++) begin
            six(c[i]);
            n = 0;
            do begin @(posedge pclk); n++; end while (erase_busy === 1'b1 && n < 300);
            check(n >= l[i] - 2 && n <= l[i] + 3, 1);
        end
        $display("lock and erase test done");
    endtask
    task t_reset;
        unlock(8'h90);
        reset_dut();
        repeat (10) @(posedge pclk);
        apb(0, 12'h010, 32'h0);
        check(rd & 32'h1, 32'h0);
        rdarr(19'h0);
        check(rd & 32'hFF, 32'hA5);
        apb(0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("reset test done");
    endtask
    initial begin
        t_power();
        t_id();
        t_locks_erase();
        t_reset();
        end_sim();
    end
endmodule

// File: hw/flash_id_defs.svh
// constants of the flash identification, lock readout and erase sequencer
// ==========================================================================
// Overview of operation
// - id mode returns maker/device code by address bit0
// - power loss leaves id mode, back to array read
// - bit0/bit1 show software locks of 64K/16K boot
// - bit2 shows boot-lock pin hardware lock
// - bit3 shows write-protect pin array lock
// - exit command returns reads to array data
// - single F0 write to any address exits
// - command address bits 14:0, data bits 7:0
// - sector/page erase done within 25 ms
// - chip erase done within 100 ms
// - reads after 100 us, writes after 5 ms
// - three-write and single-write exits both honoured
`ifndef FLASH_ID_DEFS_SVH
`define FLASH_ID_DEFS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define CMD_ADDR_OFS 12'h000
`define CMD_DATA_OFS 12'h004
`define READ_ADDR_OFS 12'h008
`define READ_DATA_OFS 12'h00C
`define STATUS_OFS 12'h010
`define LOCK_OFS 12'h014

// ==========================================================================
// command codes and addresses
`define UNLOCK_ADDR1 15'h5555
`define UNLOCK_ADDR2 15'h2AAA
`define UNLOCK_DATA1 8'hAA
`define UNLOCK_DATA2 8'h55
`define CMD_ID_ENTRY 8'h90
`define CMD_ID_EXIT 8'hF0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_PAGE_ERASE 8'h50
`define CMD_LOCK_64K 8'h40
`define CMD_LOCK_16K 8'h70

// ==========================================================================
// status field positions
`define ST_ID_MODE 0
`define ST_BUSY 1
`define ST_READ_OK 2
`define ST_WRITE_OK 3

// ==========================================================================
// timing (pclk 20 MHz)
`define CLK_HZ 20000000
`define T_PAGE_ERASE_MS 25
`define T_CHIP_ERASE_MS 100
`define T_PU_READ_US 100
`define T_PU_WRITE_MS 5
`define PAGE_ERASE_CYC (`T_PAGE_ERASE_MS * (`CLK_HZ / 1000))
`define CHIP_ERASE_CYC (`T_CHIP_ERASE_MS * (`CLK_HZ / 1000))
`define PU_READ_CYC (`T_PU_READ_US * (`CLK_HZ / 1000000))
`define PU_WRITE_CYC (`T_PU_WRITE_MS * (`CLK_HZ / 1000))

`endif

// File: hw/flash_id_lock_status_readout.sv
// flash identification, lock readout and erase timing sequencer, apb slave
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "flash_id_defs.svh"

module flash_id_lock_status_readout
    import flash_id_pkg::*;
#(
    parameter logic [7:0] MANUFACTURER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hC3, // arbitrary value
    parameter int PAGE_ERASE_CYCLES = `PAGE_ERASE_CYC,
    parameter int CHIP_ERASE_CYCLES = `CHIP_ERASE_CYC,
    parameter int PU_READ_CYCLES = `PU_READ_CYC,
    parameter int PU_WRITE_CYCLES = `PU_WRITE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lock pins, active low
    input wire logic top_block_lock_pin_n,
    input wire logic write_protect_pin_n,
    // array read port
    output logic [18:0] array_addr,
    input wire logic [7:0] array_data,
    // erase status
    output logic erase_busy
);

    // ==========================================================================
    // pin synchronisers, bit 0 boot-lock pin, bit 1 write-protect pin
    localparam int PIN_COUNT = 2;
    logic [PIN_COUNT-1:0] pin_raw_n;
    logic [PIN_COUNT-1:0] pin_lock;

    assign pin_raw_n = {write_protect_pin_n, top_block_lock_pin_n};

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin_sync
        logic [1:0] sync_reg, sync_next;

        always_comb begin
            sync_next = {sync_reg[0], pin_raw_n[i]};
        end

        // released level after reset: unlocked until the pin is seen
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_reg <= 2'h3;
            end else if (clk_en) begin
                sync_reg <= sync_next;
            end
        end

        // only the second stage feeds logic
        assign pin_lock[i] = !sync_reg[1];
    end

    // ==========================================================================
    // apb decode
    logic wr_fire, rd_setup;
    logic [14:0] cmd_addr;
    logic [7:0] cmd_data;
    logic mapped;

    assign wr_fire = psel && penable && pwrite && clk_en;
    // read data captured in the setup cycle, so prdata leaves a flip-flop
    assign rd_setup = psel && !penable && !pwrite && clk_en;
    assign pready = 1'b1;
    assign mapped = (paddr == `CMD_ADDR_OFS) || (paddr == `CMD_DATA_OFS)
        || (paddr == `READ_ADDR_OFS) || (paddr == `READ_DATA_OFS)
        || (paddr == `STATUS_OFS) || (paddr == `LOCK_OFS);
    assign pslverr = psel && penable && !mapped;
    assign cmd_data = pwdata[7:0];

    // ==========================================================================
    // state registers
    seq_state_t seq_reg, seq_next;
    logic id_mode_reg, id_mode_next;
    logic lock64_reg, lock64_next;
    logic lock16_reg, lock16_next;
    logic [18:0] cmd_addr_reg, cmd_addr_next;
    logic [18:0] rd_addr_reg, rd_addr_next;
    logic [26:0] erase_cnt_reg, erase_cnt_next;
    logic [23:0] pu_cnt_reg, pu_cnt_next;
    logic [31:0] prdata_reg, prdata_next;
    logic read_ok, write_ok, cmd_write;
    logic erase_page_go, erase_chip_go;

    assign cmd_addr = cmd_addr_reg[14:0];
    assign read_ok = pu_cnt_reg >= 24'(PU_READ_CYCLES);
    assign write_ok = pu_cnt_reg >= 24'(PU_WRITE_CYCLES);
    assign cmd_write = wr_fire && (paddr == `CMD_DATA_OFS) && write_ok
        && (erase_cnt_reg == 27'h0);

    // ==========================================================================
    // command sequencer
    always_comb begin
        seq_next = seq_reg;
        id_mode_next = id_mode_reg;
        lock64_next = lock64_reg;
        lock16_next = lock16_reg;
        cmd_addr_next = cmd_addr_reg;
        erase_page_go = 1'b0;
        erase_chip_go = 1'b0;
        if (wr_fire && paddr == `CMD_ADDR_OFS) begin
            cmd_addr_next = pwdata[18:0];
        end
        if (cmd_write) begin
            seq_next = SEQ_IDLE;
            if (cmd_data == `CMD_ID_EXIT) begin
                id_mode_next = 1'b0;
            end
            case (seq_reg)
                SEQ_IDLE: begin
                    if (cmd_addr == `UNLOCK_ADDR1 && cmd_data == `UNLOCK_DATA1) begin
                        seq_next = SEQ_UNLOCK1;
                    end
                end
                SEQ_UNLOCK1: begin
                    if (cmd_addr == `UNLOCK_ADDR2 && cmd_data == `UNLOCK_DATA2) begin
                        seq_next = SEQ_UNLOCK2;
                    end
                end
                SEQ_UNLOCK2: begin
                    if (cmd_addr == `UNLOCK_ADDR1) begin
                        if (cmd_data == `CMD_ID_ENTRY) begin
                            id_mode_next = 1'b1;
                        end else if (cmd_data == `CMD_ERASE_SETUP) begin
                            seq_next = SEQ_ERASE_SETUP;
                        end
                    end
                end
                SEQ_ERASE_SETUP: begin
                    if (cmd_addr == `UNLOCK_ADDR1 && cmd_data == `UNLOCK_DATA1) begin
                        seq_next = SEQ_ERASE_UNLOCK1;
                    end
                end
                SEQ_ERASE_UNLOCK1: begin
                    if (cmd_addr == `UNLOCK_ADDR2 && cmd_data == `UNLOCK_DATA2) begin
                        seq_next = SEQ_ERASE_UNLOCK2;
                    end
                end
                SEQ_ERASE_UNLOCK2: begin
                    if (cmd_data == `CMD_SECTOR_ERASE || cmd_data == `CMD_PAGE_ERASE) begin
                        erase_page_go = 1'b1;
                    end else if (cmd_addr == `UNLOCK_ADDR1) begin
                        if (cmd_data == `CMD_CHIP_ERASE) begin
                            erase_chip_go = 1'b1;
                        end else if (cmd_data == `CMD_LOCK_64K) begin
                            lock64_next = 1'b1;
                        end else if (cmd_data == `CMD_LOCK_16K) begin
                            lock16_next = 1'b1;
                        end
                    end
                end
                default: begin
                    seq_next = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_reg <= SEQ_IDLE;
            id_mode_reg <= 1'b0;
            lock64_reg <= 1'b0;
            lock16_reg <= 1'b0;
            cmd_addr_reg <= 19'h0;
        end else if (clk_en) begin
            seq_reg <= seq_next;
            id_mode_reg <= id_mode_next;
            lock64_reg <= lock64_next;
            lock16_reg <= lock16_next;
            cmd_addr_reg <= cmd_addr_next;
        end
    end

    // ==========================================================================
    // erase timer, loads only when idle since command writes wait for it
    always_comb begin
        erase_cnt_next = erase_cnt_reg;
        if (erase_page_go) begin
            erase_cnt_next = 27'(PAGE_ERASE_CYCLES);
        end else if (erase_chip_go) begin
            erase_cnt_next = 27'(CHIP_ERASE_CYCLES);
        end else if (erase_cnt_reg != 27'h0) begin
            erase_cnt_next = erase_cnt_reg - 27'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_cnt_reg <= 27'h0;
        end else if (clk_en) begin
            erase_cnt_reg <= erase_cnt_next;
        end
    end

    assign erase_busy = erase_cnt_reg != 27'h0;

    // ==========================================================================
    // power-up counter
    always_comb begin
        pu_cnt_next = pu_cnt_reg;
        // saturates once writes are allowed, reads open earlier
        if (!write_ok) begin
            pu_cnt_next = pu_cnt_reg + 24'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_cnt_reg <= 24'h0;
        end else if (clk_en) begin
            pu_cnt_reg <= pu_cnt_next;
        end
    end

    // ==========================================================================
    // read address, drives the array port
    always_comb begin
        rd_addr_next = rd_addr_reg;
        if (wr_fire && paddr == `READ_ADDR_OFS) begin
            rd_addr_next = pwdata[18:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_addr_reg <= 19'h0;
        end else if (clk_en) begin
            rd_addr_reg <= rd_addr_next;
        end
    end

    assign array_addr = rd_addr_reg;

    // ==========================================================================
    // read path
    logic [7:0] id_byte;
    logic [7:0] lock_byte;
    logic [31:0] status_word;

    assign lock_byte = {4'h0, pin_lock[1], pin_lock[0], lock16_reg,
        lock64_reg};

    always_comb begin
        if (rd_addr_reg[18:1] == 18'h0) begin
            id_byte = rd_addr_reg[0] ? DEVICE_CODE : MANUFACTURER_CODE;
        end else begin
            id_byte = lock_byte;
        end
    end

    always_comb begin
        status_word = 32'h0;
        status_word[`ST_ID_MODE] = id_mode_reg;
        status_word[`ST_BUSY] = erase_busy;
        status_word[`ST_READ_OK] = read_ok;
        status_word[`ST_WRITE_OK] = write_ok;
    end

    // word taken in the setup cycle stands through the access phase
    always_comb begin
        prdata_next = prdata_reg;
        if (rd_setup) begin
            case (paddr)
                `CMD_ADDR_OFS: prdata_next = {13'h0, cmd_addr_reg};
                `READ_ADDR_OFS: prdata_next = {13'h0, rd_addr_reg};
                `READ_DATA_OFS: begin
                    if (!read_ok) begin
                        prdata_next = 32'h0;
                    end else if (id_mode_reg) begin
                        prdata_next = {24'h0, id_byte};
                    end else begin
                        prdata_next = {24'h0, array_data};
                    end
                end
                `STATUS_OFS: prdata_next = status_word;
                `LOCK_OFS: prdata_next = {24'h0, lock_byte};
                default: prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (clk_en) begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

endmodule

// File: hw/flash_id_pkg.sv
// types of the flash identification sequencer
package flash_id_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_UNLOCK1,
        SEQ_UNLOCK2,
        SEQ_ERASE_SETUP,
        SEQ_ERASE_UNLOCK1,
        SEQ_ERASE_UNLOCK2
    } seq_state_t;
endpackage
